// *** src/bccal_top.v ***
// bcd time-of-day clock and calendar with alarm, entry checking and register port
// How it works
// - free-running slow reference clock, never gated
// - all time and calendar counters hold bcd values; the prescaler counts in binary
// - calendar spans years 1900 to 2099
// - hours in 24-hour or 12-hour with pm
// - every year divisible by four is leap
// - reset loads Thursday, January 1st, 1998
// - seconds tick once a second, carries ripple up
// - alarm matches enabled fields, flags, may interrupt
// - seconds-only alarm fires once a minute while time counts; with the time update request held it fires on every tick
// - bad write leaves target, sets error flag
// - error flag clears only on good write
// - century 19 to 20, year legal bcd
// - date within 01 to 31
// - month 01 to 12, long enough for date
// - date checked against written month and year
// - interrupt ored onto shared system line
// - update request stops counting until software clears it
// - hour range by mode, no pm in 24-hour
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "bccal_regs.vh"
module bccal_top
#(
   parameter SLOW_HZ = `BCCAL_SLOW_HZ,
   parameter PRE_W   = 15
)
(
   input  wire        clk,
   input  wire        reset,
   input  wire        slowRefClk,
   input  wire        otherSysIrq,
   input  wire [7:0]  addr,
   input  wire [31:0] wrData,
   input  wire        wrEn,
   input  wire        rdEn,
   output reg  [31:0] rdData_ff,
   output reg         sharedSystemIrqLine_ff
);
   localparam integer     PRE_END  = SLOW_HZ - 1;
   localparam [PRE_W-1:0] PRE_LAST = PRE_END[PRE_W-1:0];
   reg             slowS1_ff, slowS2_ff, slowPrev_ff;
   reg [PRE_W-1:0] prescale_ff;
   reg             tick_ff, tickDly_ff;
   reg [6:0]       secs_ff, mins_ff, cent_ff;
   reg [5:0]       hrs_ff, date_ff;
   reg             pm_ff, hrMode_ff;
   reg [2:0]       dow_ff;
   reg [4:0]       mon_ff;
   reg [7:0]       year_ff;
   reg             time_update_request_ff, calendar_update_request_ff;
   reg [31:0]      tAlm_ff, cAlm_ff;
   reg [2:0]       stat_ff, imask_ff;
   reg [3:0]       valid_ff;
   wire [31:0]     calRst = `BCCAL_CAL_RST;
   // leap test on bcd year: tens even with 0/4/8, or tens odd with 2/6
   function leapYear;
      input [7:0] y;
      leapYear = y[4] ? ((y[3:0] == 4'h2) || (y[3:0] == 4'h6))
                      : ((y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8));
   endfunction
   function [7:0] monLen;
      input [4:0] m;
      input [7:0] y;
      begin
         case (m)
            5'h02:   monLen = leapYear(y) ? 8'h29 : 8'h28;
            5'h04:   monLen = 8'h30;
            5'h06:   monLen = 8'h30;
            5'h09:   monLen = 8'h30;
            5'h11:   monLen = 8'h30;
            default: monLen = 8'h31;
         endcase
      end
   endfunction
   // slow clock is a pin: two flops, then edge detect on the second only
   always @(posedge clk)
   begin
      if (reset)
      begin
         slowS1_ff   <= 1'b0;
         slowS2_ff   <= 1'b0;
         slowPrev_ff <= 1'b0;
      end
      else
      begin
         slowS1_ff   <= slowRefClk;
         slowS2_ff   <= slowS1_ff;
         slowPrev_ff <= slowS2_ff;
      end
   end
   wire slowEdge = slowS2_ff & ~slowPrev_ff;
   // prescaler ignores update requests so time never slips
   always @(posedge clk)
   begin
      if (reset)
      begin
         prescale_ff <= {PRE_W{1'b0}};
         tick_ff     <= 1'b0;
         tickDly_ff  <= 1'b0;
      end
      else
      begin
         tick_ff    <= slowEdge && (prescale_ff == PRE_LAST);
         tickDly_ff <= tick_ff;
         if (slowEdge)
            prescale_ff <= (prescale_ff == PRE_LAST) ? {PRE_W{1'b0}} : prescale_ff + 1'b1;
      end
   end
   // counter steps
   wire [7:0] secNxt, minNxt, hrNxt, dateNxt, monNxt, yearNxt, dowNxt;
   wire       secWrap, minWrap, hrWrap, dateWrap, monWrap, yearWrap, dowWrap;
   wire [7:0] hrLo = hrMode_ff ? 8'h01 : 8'h00;
   wire [7:0] hrHi = hrMode_ff ? 8'h12 : 8'h23;
   bccal_bcd_step uSecStep (.val({1'b0, secs_ff}), .lo(8'h00), .hi(8'h59),
      .nxt(secNxt), .wrap(secWrap));
   bccal_bcd_step uMinStep (.val({1'b0, mins_ff}), .lo(8'h00), .hi(8'h59),
      .nxt(minNxt), .wrap(minWrap));
   bccal_bcd_step uHrStep (.val({2'b00, hrs_ff}), .lo(hrLo), .hi(hrHi),
      .nxt(hrNxt), .wrap(hrWrap));
   bccal_bcd_step uDateStep (.val({2'b00, date_ff}), .lo(8'h01), .hi(monLen(mon_ff, year_ff)),
      .nxt(dateNxt), .wrap(dateWrap));
   bccal_bcd_step uMonStep (.val({3'b000, mon_ff}), .lo(8'h01), .hi(8'h12),
      .nxt(monNxt), .wrap(monWrap));
   bccal_bcd_step uYearStep (.val(year_ff), .lo(8'h00), .hi(8'h99),
      .nxt(yearNxt), .wrap(yearWrap));
   bccal_bcd_step uDowStep (.val({5'h00, dow_ff}), .lo(8'h01), .hi(8'h07),
      .nxt(dowNxt), .wrap(dowWrap));
   wire secAdv  = tick_ff & ~time_update_request_ff;
   wire minAdv  = secAdv & secWrap;
   wire hrAdv   = minAdv & minWrap;
   wire pmFlip  = hrAdv & hrMode_ff & (hrs_ff == 6'h11);
   wire dayAdv  = hrAdv & (hrMode_ff ? (pmFlip & pm_ff) : hrWrap);
   wire calAdv  = dayAdv & ~calendar_update_request_ff;
   wire monAdv  = calAdv & dateWrap;
   wire yearAdv = monAdv & monWrap;
   wire centAdv = yearAdv & yearWrap;
   // entry checks on the written word; time and alarm share field positions
   wire secOk, minOk, hrOk, monOk, dateOk, centOk, yearOk, dowOk;
   wire [7:0] wrMon  = {3'b000, wrData[20:16]};
   wire [7:0] dateHi = (addr == `BCCAL_CAL_OFS) ? monLen(wrData[20:16], wrData[15:8]) : 8'h31;
   bccal_bcd_range uSecChk (.val({1'b0, wrData[6:0]}), .lo(8'h00), .hi(8'h59), .ok(secOk));
   bccal_bcd_range uMinChk (.val({1'b0, wrData[14:8]}), .lo(8'h00), .hi(8'h59), .ok(minOk));
   bccal_bcd_range uHrChk (.val({2'b00, wrData[21:16]}), .lo(hrLo), .hi(hrHi), .ok(hrOk));
   bccal_bcd_range uMonChk (.val(wrMon), .lo(8'h01), .hi(8'h12), .ok(monOk));
   bccal_bcd_range uDateChk (.val({2'b00, wrData[29:24]}), .lo(8'h01), .hi(dateHi),
      .ok(dateOk));
   bccal_bcd_range uCentChk (.val({1'b0, wrData[6:0]}), .lo(8'h19), .hi(8'h20), .ok(centOk));
   bccal_bcd_range uYearChk (.val(wrData[15:8]), .lo(8'h00), .hi(8'h99), .ok(yearOk));
   bccal_bcd_range uDowChk (.val({5'h00, wrData[23:21]}), .lo(8'h01), .hi(8'h07), .ok(dowOk));
   wire pmBad  = ~hrMode_ff & wrData[`BCCAL_PM_BIT];
   wire timeOk = secOk & minOk & hrOk & ~pmBad;
   wire calOk  = centOk & yearOk & monOk & dowOk & dateOk;
   wire calmOk = monOk & dateOk;
   wire wrCtrl  = wrEn && (addr == `BCCAL_CTRL_OFS);
   wire wrMode  = wrEn && (addr == `BCCAL_MODE_OFS);
   wire wrTime  = wrEn && (addr == `BCCAL_TIME_OFS) && time_update_request_ff;
   wire wrCal   = wrEn && (addr == `BCCAL_CAL_OFS) && calendar_update_request_ff;
   wire wrTalm  = wrEn && (addr == `BCCAL_TALM_OFS);
   wire wrCalm  = wrEn && (addr == `BCCAL_CALM_OFS);
   wire wrSclr  = wrEn && (addr == `BCCAL_SCLR_OFS);
   wire wrIen   = wrEn && (addr == `BCCAL_IEN_OFS);
   wire wrIdis  = wrEn && (addr == `BCCAL_IDIS_OFS);
   // time counters; writes only land while counting is stopped
   always @(posedge clk)
   begin
      if (reset)
      begin
         secs_ff <= 7'h00;
         mins_ff <= 7'h00;
         hrs_ff  <= 6'h00;
         pm_ff   <= 1'b0;
      end
      else if (wrTime)
      begin
         if (timeOk)
         begin
            secs_ff <= wrData[6:0];
            mins_ff <= wrData[14:8];
            hrs_ff  <= wrData[21:16];
            pm_ff   <= wrData[`BCCAL_PM_BIT];
         end
      end
      else
      begin
         if (secAdv)
            secs_ff <= secNxt[6:0];
         if (minAdv)
            mins_ff <= minNxt[6:0];
         if (hrAdv)
            hrs_ff <= hrNxt[5:0];
         if (pmFlip)
            pm_ff <= ~pm_ff;
      end
   end
   // calendar counters; reset date is Thursday 01 January 1998
   always @(posedge clk)
   begin
      if (reset)
      begin
         cent_ff <= calRst[6:0];
         year_ff <= calRst[15:8];
         mon_ff  <= calRst[20:16];
         dow_ff  <= calRst[23:21];
         date_ff <= calRst[29:24];
      end
      else if (wrCal)
      begin
         if (calOk)
         begin
            cent_ff <= wrData[6:0];
            year_ff <= wrData[15:8];
            mon_ff  <= wrData[20:16];
            dow_ff  <= wrData[23:21];
            date_ff <= wrData[29:24];
         end
      end
      else
      begin
         if (calAdv)
         begin
            date_ff <= dateNxt[5:0];
            dow_ff  <= dowNxt[2:0];
         end
         if (monAdv)
            mon_ff <= monNxt[4:0];
         if (yearAdv)
            year_ff <= yearNxt;
         if (centAdv)
            cent_ff <= (cent_ff == 7'h19) ? 7'h20 : 7'h19;
      end
   end
   // alarm fields; a reject keeps the old setting
   always @(posedge clk)
   begin
      if (reset)
      begin
         tAlm_ff <= `BCCAL_TALM_RST;
         cAlm_ff <= `BCCAL_CALM_RST;
      end
      else
      begin
         if (wrTalm && timeOk)
            tAlm_ff <= wrData & 32'h00FFFFFF;
         if (wrCalm && calmOk)
            cAlm_ff <= wrData & 32'hBF9F0000;
      end
   end
   // a disabled field always matches; no field enabled never fires
   wire secEn  = tAlm_ff[`BCCAL_SECEN_BIT];
   wire minEn  = tAlm_ff[`BCCAL_MINEN_BIT];
   wire hrEn   = tAlm_ff[`BCCAL_HREN_BIT];
   wire monEn  = cAlm_ff[`BCCAL_MONEN_BIT];
   wire datEn  = cAlm_ff[`BCCAL_DATEN_BIT];
   wire secHit = ~secEn | (secs_ff == tAlm_ff[6:0]);
   wire minHit = ~minEn | (mins_ff == tAlm_ff[14:8]);
   wire hrHit  = ~hrEn | ({pm_ff, hrs_ff} == tAlm_ff[22:16]);
   wire monHit = ~monEn | (mon_ff == cAlm_ff[20:16]);
   wire datHit = ~datEn | (date_ff == cAlm_ff[29:24]);
   wire anyEn  = secEn | minEn | hrEn | monEn | datEn;
   // judged one cycle after the tick, once the counters have settled
   wire alarmEv = tickDly_ff & anyEn & secHit & minHit & hrHit & monHit & datHit;
   wire [2:0] statSet = {tick_ff, alarmEv, tick_ff & (time_update_request_ff | calendar_update_request_ff)};
   wire [2:0] statClr = wrSclr ? wrData[2:0] : 3'b000;
   // control, status, mask and validity
   always @(posedge clk)
   begin
      if (reset)
      begin
         hrMode_ff <= 1'b0;
         time_update_request_ff <= 1'b0;
         calendar_update_request_ff <= 1'b0;
         stat_ff   <= 3'b000;
         imask_ff  <= 3'b000;
         valid_ff  <= 4'h0;
      end
      else
      begin
         if (wrCtrl)
         begin
            time_update_request_ff <= wrData[`BCCAL_CTRL_UPDT];
            calendar_update_request_ff <= wrData[`BCCAL_CTRL_UPDC];
         end
         if (wrMode)
            hrMode_ff <= wrData[`BCCAL_MODE_H12];
         // a new event wins over a clear in the same cycle
         stat_ff  <= (stat_ff & ~statClr) | statSet;
         imask_ff <= (imask_ff | (wrIen ? wrData[2:0] : 3'b000))
                     & ~(wrIdis ? wrData[2:0] : 3'b000);
         // software has no clear path; only a good write of the same kind clears
         if (wrTime)
            valid_ff[`BCCAL_NV_TIME] <= ~timeOk;
         if (wrCal)
            valid_ff[`BCCAL_NV_CAL] <= ~calOk;
         if (wrTalm)
            valid_ff[`BCCAL_NV_TALM] <= ~timeOk;
         if (wrCalm)
            valid_ff[`BCCAL_NV_CALM] <= ~calmOk;
      end
   end
   // counters settle within a cycle of the tick, so a double read is safe
   always @(posedge clk)
   begin
      if (reset)
      begin
         rdData_ff              <= 32'h00000000;
         sharedSystemIrqLine_ff <= 1'b0;
      end
      else
      begin
         sharedSystemIrqLine_ff <= (|(stat_ff & imask_ff)) | otherSysIrq;
         if (!rdEn)
            rdData_ff <= 32'h00000000;
         else
         begin
            case (addr)
               `BCCAL_CTRL_OFS:  rdData_ff <= {30'h00000000, calendar_update_request_ff, time_update_request_ff};
               `BCCAL_MODE_OFS:  rdData_ff <= {31'h00000000, hrMode_ff};
               `BCCAL_TIME_OFS:  rdData_ff <= {9'h000, pm_ff, hrs_ff, 1'b0, mins_ff,
                                               1'b0, secs_ff};
               `BCCAL_CAL_OFS:   rdData_ff <= {2'b00, date_ff, dow_ff, mon_ff, year_ff,
                                               1'b0, cent_ff};
               `BCCAL_TALM_OFS:  rdData_ff <= tAlm_ff;
               `BCCAL_CALM_OFS:  rdData_ff <= cAlm_ff;
               `BCCAL_STAT_OFS:  rdData_ff <= {29'h00000000, stat_ff};
               `BCCAL_IMSK_OFS:  rdData_ff <= {29'h00000000, imask_ff};
               `BCCAL_VALID_OFS: rdData_ff <= {28'h0000000, valid_ff};
               default:          rdData_ff <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

// *** src/bccal_regs.vh ***
// register map, field positions, reset values and timing counts of the calendar clock
`ifndef BCCAL_REGS_VH
`define BCCAL_REGS_VH
`define BCCAL_CTRL_OFS   8'h00
`define BCCAL_MODE_OFS   8'h04
`define BCCAL_TIME_OFS   8'h08
`define BCCAL_CAL_OFS    8'h0C
`define BCCAL_TALM_OFS   8'h10
`define BCCAL_CALM_OFS   8'h14
`define BCCAL_STAT_OFS   8'h18
`define BCCAL_SCLR_OFS   8'h1C
`define BCCAL_IEN_OFS    8'h20
`define BCCAL_IDIS_OFS   8'h24
`define BCCAL_IMSK_OFS   8'h28
`define BCCAL_VALID_OFS  8'h2C
`define BCCAL_CTRL_UPDT  0
`define BCCAL_CTRL_UPDC  1
`define BCCAL_MODE_H12   0
`define BCCAL_PM_BIT     22
`define BCCAL_SECEN_BIT  7
`define BCCAL_MINEN_BIT  15
`define BCCAL_HREN_BIT   23
`define BCCAL_MONEN_BIT  23
`define BCCAL_DATEN_BIT  31
`define BCCAL_ST_ACK     0
`define BCCAL_ST_ALM     1
`define BCCAL_ST_SEC     2
`define BCCAL_NV_TIME    0
`define BCCAL_NV_CAL     1
`define BCCAL_NV_TALM    2
`define BCCAL_NV_CALM    3
`define BCCAL_CAL_RST    32'h01819819
`define BCCAL_TALM_RST   32'h00000000
`define BCCAL_CALM_RST   32'h01010000
`define BCCAL_SLOW_HZ    32768
`endif

// *** src/bccal_bcd_range.v ***
// two-digit bcd digit check plus inclusive range check
`timescale 1ns/1ps
module bccal_bcd_range
(
   input  wire [7:0] val,
   input  wire [7:0] lo,
   input  wire [7:0] hi,
   output wire       ok
);
   // bcd order matches numeric order once both digits are legal
   assign ok = (val[3:0] <= 4'h9) && (val[7:4] <= 4'h9) && (val >= lo) && (val <= hi);
endmodule

// *** src/bccal_bcd_step.v ***
// two-digit bcd increment with wrap from hi back to lo
`timescale 1ns/1ps
module bccal_bcd_step
(
   input  wire [7:0] val,
   input  wire [7:0] lo,
   input  wire [7:0] hi,
   output wire [7:0] nxt,
   output wire       wrap
);
   wire [3:0] tensUp;
   wire [3:0] unitsUp;
   assign tensUp  = val[7:4] + 4'h1;
   assign unitsUp = val[3:0] + 4'h1;
   // >= so an out-of-range value still recovers on the next step
   assign wrap = (val >= hi);
   assign nxt  = wrap ? lo : ((val[3:0] == 4'h9) ? {tensUp, 4'h0} : {val[7:4], unitsUp});
endmodule

// *** testbench/bccal_chk_asserts.sv ***
// checker on the calendar clock's register port and interrupt line
`timescale 1ns/1ps
`include "bccal_regs.vh"
module bccal_chk
#(
   parameter SLOW_HZ = `BCCAL_SLOW_HZ,
   parameter PRE_W   = 15
)
(
   input wire        clk,
   input wire        reset,
   input wire        slowRefClk,
   input wire        otherSysIrq,
   input wire [7:0]  addr,
   input wire [31:0] wrData,
   input wire        wrEn,
   input wire        rdEn,
   input wire [31:0] rdData_ff,
   input wire        sharedSystemIrqLine_ff
);
   logic [2:0] msk_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // shadow of the mask from bus traffic; only one offset per cycle, so no tie
   always @(posedge clk)
      if (reset)
         msk_ff <= 3'h0;
      else if (wrEn && addr == `BCCAL_IEN_OFS)
         msk_ff <= msk_ff | wrData[2:0];
      else if (wrEn && addr == `BCCAL_IDIS_OFS)
         msk_ff <= msk_ff & ~wrData[2:0];
   sequence readOf(logic [7:0] a);
      rdEn && addr == a;
   endsequence
   AST_TIME_BCD: assert property (readOf(`BCCAL_TIME_OFS) |=>
      rdData_ff[3:0] <= 4'h9 && rdData_ff[6:4] <= 3'h5 && rdData_ff[11:8] <= 4'h9
      && rdData_ff[14:12] <= 3'h5 && !rdData_ff[7] && rdData_ff[31:23] == 9'h0)
      else $error("time word not bcd");
   AST_HOUR: assert property (readOf(`BCCAL_TIME_OFS) |=>
      rdData_ff[21:16] <= 6'h23 && rdData_ff[19:16] <= 4'h9)
      else $error("hour out of range");
   AST_CENT: assert property (readOf(`BCCAL_CAL_OFS) |=>
      (rdData_ff[6:0] == 7'h19 || rdData_ff[6:0] == 7'h20)
      && rdData_ff[15:12] <= 4'h9 && rdData_ff[11:8] <= 4'h9)
      else $error("century or year bad");
   AST_DATE: assert property (readOf(`BCCAL_CAL_OFS) |=>
      rdData_ff[29:24] >= 6'h01 && rdData_ff[29:24] <= 6'h31 && rdData_ff[27:24] <= 4'h9)
      else $error("date out of range");
   AST_MONTH: assert property (readOf(`BCCAL_CAL_OFS) |=>
      rdData_ff[20:16] >= 5'h01 && rdData_ff[20:16] <= 5'h12 && rdData_ff[19:16] <= 4'h9
      && rdData_ff[23:21] != 3'h0)
      else $error("month or day out of range");
   AST_VALID_RO: assert property (readOf(`BCCAL_VALID_OFS) |=> rdData_ff[31:4] == 28'h0)
      else $error("validity word has stray bits");
   AST_OTHER_IRQ: assert property (otherSysIrq |=> sharedSystemIrqLine_ff)
      else $error("other interrupt not passed on");
   AST_IRQ_CAUSE: assert property (sharedSystemIrqLine_ff && !$past(otherSysIrq)
      |-> $past(msk_ff) != 3'h0)
      else $error("interrupt with no enabled cause");
   AST_RST_QUIET: assert property (disable iff (1'b0) reset
      |=> rdData_ff == 32'h0 && !sharedSystemIrqLine_ff)
      else $error("outputs not quiet after reset");
endmodule
bind bccal_top bccal_chk #(.SLOW_HZ(SLOW_HZ), .PRE_W(PRE_W)) bccal_chk_inst
(
   .clk(clk), .reset(reset), .slowRefClk(slowRefClk), .otherSysIrq(otherSysIrq),
   .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData_ff(rdData_ff),
   .sharedSystemIrqLine_ff(sharedSystemIrqLine_ff)
);

// *** testbench/bccal_sw.sv ***
// software side of the register port: one-cycle writes and reads
`timescale 1ns/1ps
module bccal_sw
(
   input  wire         clk,
   output logic [7:0]  addr,
   output logic [31:0] wrData,
   output logic        wrEn,
   output logic        rdEn,
   input  wire  [31:0] rdData
);
   initial
   begin
      addr = 8'h00;
      wrData = 32'h0;
      wrEn = 1'b0;
      rdEn = 1'b0;
   end
   // lines are not held after a strobe, so they flip to expose late sampling
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      addr <= ~a;
      wrData <= ~d;
      wrEn <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      addr <= ~a;
      rdEn <= 1'b0;
      #1 d = rdData;
   endtask
   // counters run apart from the bus; three reads at most until two agree
   task automatic rdStable(input logic [7:0] a, output logic [31:0] d);
      logic [31:0] p;
      rd(a, p);
      for (int i = 0; i < 2; i++)
      begin
         rd(a, d);
         if (d === p)
            return;
         p = d;
      end
   endtask
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the bcd calendar clock
`timescale 1ns/1ps
`include "bccal_regs.vh"
module tb_top;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        slowRefClk = 1'b0;
   logic        otherSysIrq = 1'b0;
   wire  [7:0]  addr;
   wire  [31:0] wrData;
   wire         wrEn;
   wire         rdEn;
   wire  [31:0] rdData;
   wire         irq;
   int          fails = 0;
   int          checksDone = 0;
   logic [31:0] good [0:63];
   always #5 clk = ~clk;
   // free running, unrelated in phase; four rising edges make one second here
   always #43 slowRefClk = ~slowRefClk;
   bccal_sw bccal_sw_inst (.clk(clk), .addr(addr), .wrData(wrData), .wrEn(wrEn),
      .rdEn(rdEn), .rdData(rdData));
   // a short second keeps one simulated minute near two thousand clocks
   bccal_top #(.SLOW_HZ(4), .PRE_W(3)) bccal_top_inst (.clk(clk), .reset(reset),
      .slowRefClk(slowRefClk), .otherSysIrq(otherSysIrq), .addr(addr), .wrData(wrData),
      .wrEn(wrEn), .rdEn(rdEn), .rdData_ff(rdData), .sharedSystemIrqLine_ff(irq));
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic twice);
      logic [31:0] d;
      if (twice)
         bccal_sw_inst.rdStable(a, d);
      else
         bccal_sw_inst.rd(a, d);
      chk(d, exp);
   endtask
   task automatic waitBit(input int b);
      logic [31:0] d;
      for (int i = 0; i < 1500; i++)
      begin
         bccal_sw_inst.rd(`BCCAL_STAT_OFS, d);
         if (d[b] === 1'b1)
            return;
      end
      fails++;
      report_and_stop();
   endtask
   task automatic update(input logic [31:0] req);
      bccal_sw_inst.wr(`BCCAL_CTRL_OFS, req);
      waitBit(`BCCAL_ST_ACK);
   endtask
   task automatic entry(input logic [7:0] a, input logic [31:0] d, input int vb, input logic ok);
      logic [31:0] r;
      bccal_sw_inst.wr(a, d);
      if (ok)
         good[a[7:2]] = d;
      rdChk(a, good[a[7:2]], 1'b0);
      bccal_sw_inst.rd(`BCCAL_VALID_OFS, r);
      chk({31'h0, r[vb]}, {31'h0, ~ok});
   endtask
   task automatic resetValues();
      rdChk(`BCCAL_TIME_OFS, 32'h0, 1'b0);
      rdChk(`BCCAL_CAL_OFS, 32'h01819819, 1'b0);
      rdChk(`BCCAL_CALM_OFS, 32'h01010000, 1'b0);
      rdChk(`BCCAL_MODE_OFS, 32'h0, 1'b0);
      rdChk(`BCCAL_VALID_OFS, 32'h0, 1'b0);
      rdChk(8'h30, 32'h0, 1'b0);
   endtask
   task automatic carryChain();
      update(32'h3);
      bccal_sw_inst.wr(`BCCAL_TIME_OFS, 32'h00235958);
      bccal_sw_inst.wr(`BCCAL_CTRL_OFS, 32'h0);
      bccal_sw_inst.wr(`BCCAL_SCLR_OFS, 32'h7);
      waitBit(`BCCAL_ST_SEC);
      bccal_sw_inst.wr(`BCCAL_SCLR_OFS, 32'h4);
      rdChk(`BCCAL_TIME_OFS, 32'h00235959, 1'b1);
      waitBit(`BCCAL_ST_SEC);
      rdChk(`BCCAL_TIME_OFS, 32'h0, 1'b1);
      rdChk(`BCCAL_CAL_OFS, 32'h02A19819, 1'b1);
   endtask
   task automatic entryChecks();
      // alarm words start from their reset values until a good write lands
      good[`BCCAL_TALM_OFS >> 2] = `BCCAL_TALM_RST;
      good[`BCCAL_CALM_OFS >> 2] = `BCCAL_CALM_RST;
      bccal_sw_inst.wr(`BCCAL_SCLR_OFS, 32'h7);
      update(32'h3);
      entry(`BCCAL_TIME_OFS, 32'h00230000, 0, 1'b1);
      entry(`BCCAL_TIME_OFS, 32'h00240000, 0, 1'b0);
      entry(`BCCAL_TIME_OFS, 32'h00410000, 0, 1'b0);
      entry(`BCCAL_TIME_OFS, 32'h00006000, 0, 1'b0);
      entry(`BCCAL_CAL_OFS, 32'h29220420, 1, 1'b1);
      entry(`BCCAL_CAL_OFS, 32'h29220120, 1, 1'b0);
      entry(`BCCAL_CAL_OFS, 32'h01210021, 1, 1'b0);
      entry(`BCCAL_CAL_OFS, 32'h01210A20, 1, 1'b0);
      entry(`BCCAL_CAL_OFS, 32'h01330020, 1, 1'b0);
      entry(`BCCAL_CAL_OFS, 32'h32210020, 1, 1'b0);
      entry(`BCCAL_CAL_OFS, 32'h31240020, 1, 1'b0);
      entry(`BCCAL_CAL_OFS, 32'h29220020, 1, 1'b1);
      entry(`BCCAL_TALM_OFS, 32'h000000E0, 2, 1'b0);
      entry(`BCCAL_TALM_OFS, 32'h00000082, 2, 1'b1);
      entry(`BCCAL_CALM_OFS, 32'h32000000, 3, 1'b0);
      entry(`BCCAL_CALM_OFS, 32'h01010000, 3, 1'b1);
      entry(`BCCAL_MODE_OFS, 32'h00000001, 4, 1'b1);
      entry(`BCCAL_TIME_OFS, 32'h00000000, 0, 1'b0);
      entry(`BCCAL_TIME_OFS, 32'h00130000, 0, 1'b0);
      entry(`BCCAL_TIME_OFS, 32'h00520000, 0, 1'b1);
      bccal_sw_inst.wr(`BCCAL_CTRL_OFS, 32'h0);
   endtask
   task automatic alarmIrq();
      bccal_sw_inst.wr(`BCCAL_SCLR_OFS, 32'h7);
      bccal_sw_inst.wr(`BCCAL_IEN_OFS, 32'h2);
      waitBit(`BCCAL_ST_ALM);
      chk({31'h0, irq}, 32'h1);
      rdChk(`BCCAL_TIME_OFS, 32'h00520002, 1'b1);
      // clear only after the match second is over, so the flag cannot return
      bccal_sw_inst.wr(`BCCAL_SCLR_OFS, 32'h4);
      waitBit(`BCCAL_ST_SEC);
      bccal_sw_inst.wr(`BCCAL_SCLR_OFS, 32'h2);
      @(posedge clk);
      #1 chk({31'h0, irq}, 32'h0);
      bccal_sw_inst.wr(`BCCAL_IDIS_OFS, 32'h2);
      waitBit(`BCCAL_ST_ALM);
      chk({31'h0, irq}, 32'h0);
      rdChk(`BCCAL_TIME_OFS, 32'h00520102, 1'b1);
      // all five fields armed: month, date and the pm hour must agree as well
      bccal_sw_inst.wr(`BCCAL_TALM_OFS, 32'h00D28185);
      bccal_sw_inst.wr(`BCCAL_CALM_OFS, 32'hA9820000);
      bccal_sw_inst.wr(`BCCAL_SCLR_OFS, 32'h2);
      waitBit(`BCCAL_ST_ALM);
      rdChk(`BCCAL_TIME_OFS, 32'h00520105, 1'b1);
   endtask
   task automatic otherIrq();
      @(posedge clk);
      otherSysIrq <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({31'h0, irq}, 32'h1);
      @(posedge clk);
      otherSysIrq <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk({31'h0, irq}, 32'h0);
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      resetValues();
      carryChain();
      entryChecks();
      alarmIrq();
      otherIrq();
      report_and_stop();
   end
endmodule
